// file: design/mds_pkg.sv
// Package of constants, state encoding and helpers for the multiply/divide sequencer.
//
// Functional notes
// RULE1: Product goes to named register and to named register ORed with one.
// RULE2: Multiplier in source reg, multiplicand in destination reg, product built by add-and-shift.
// RULE3: Multiplier sign bit is copied into buffer register top after every shift; the code keeps the top at zero while the partial product is zero.
// RULE4: Branches look at multiplicand bit and counter as held at state start.
// RULE5: First setup state loads destination operand and sets shift counter to fifteen.
// RULE6: Second setup state clears buffer register and decrements shift counter.
// RULE7: Fifteen cycles: add source to buffer when low bit set, then shift.
// RULE8: Correct the product only when the multiplicand is negative.
// RULE9: After fifteen cycles subtract multiplier from high half if sign bit set.
// RULE10: Correct and no-correct states store high half and set codes on it.
// RULE11: Final state stores low half to named register ORed with one.
// RULE12: Final codes cover whole product: zero on all 32 bits, carry if not one word.
// RULE13: After final store go to break service if break sample saw a request.
// RULE14: Divide subtracts divisor on equal signs and adds it on differing signs.
// RULE15: Division is non-restoring; later steps of opposite sense repair underflow.
// RULE16: Subtracting step sets quotient bit without underflow, clears it with underflow.
// RULE17: Adding step clears quotient bit without underflow, sets it with underflow.
// RULE18: Divisor weight halves before each quotient step, done as a dividend left shift.
// RULE19: Quotient too large to represent is flagged as overflow, no result.
// RULE20: Underflow is a reduction that flips the partial remainder sign.
// RULE21: Divisor in source reg, dividend high in buffer, low in destination reg.
// RULE22: Zero divisor aborts and sets carry, overflow and zero codes.
// RULE23: Register file is written only in the product store states.
`default_nettype none

package mds_pkg;

  localparam logic [3:0]  SC_INIT   = 4'hF;
  localparam logic [3:0]  SC_ZERO   = 4'h0;
  localparam logic [3:0]  SC_STEP   = 4'h1;
  localparam logic [2:0]  ODD_REG   = 3'h1;
  localparam logic [15:0] WORD_ZERO = 16'h0000;

  typedef enum logic [3:0] {
    idle_state,
    product_load_state,
    product_clear_state,
    product_add_shift_state,
    product_shift_state,
    product_nocorrect_state,
    product_correct_state,
    product_low_store_state,
    div_check_state,
    div_overflow_state,
    div_step_state,
    div_done_state
  } mds_state_t;

  typedef struct packed {
    mds_state_t  microaddress_register;
    logic [15:0] source_operand_reg;
    logic [15:0] destination_operand_reg;
    logic [15:0] buffer_reg;
    logic        buffer_ext;
    logic [3:0]  shift_counter;
    logic [2:0]  named_reg;
    logic        break_request_sample;
    logic        busy;
    logic        wr_en;
    logic [2:0]  wr_sel;
    logic [15:0] wr_data;
    logic        cc_load;
    logic        cc_n;
    logic        cc_z;
    logic        cc_v;
    logic        cc_c;
    logic        goto_break;
    logic        goto_fetch;
    logic        div_done;
    logic        div_error;
    logic [15:0] quotient;
    logic [15:0] remainder;
  } mds_regs_t;

  function automatic logic [17:0] mds_sx18(input logic [15:0] w);
    return {{2{w[15]}}, w};
  endfunction : mds_sx18

  function automatic logic [17:0] mds_zx18(input logic [15:0] w);
    return {2'b00, w};
  endfunction : mds_zx18

endpackage : mds_pkg

`default_nettype wire

// file: design/mds_addsub.sv
// Shared 18-bit adder/subtractor of the sequencer datapath.
`default_nettype none

module mds_addsub
  import mds_pkg::*;
(
  input  wire logic [17:0] op_a,
  input  wire logic [17:0] op_b,
  input  wire logic        sub,
  output logic      [17:0] sum
);

  always_comb
  begin
    sum = sub ? (op_a - op_b) : (op_a + op_b);
  end

endmodule : mds_addsub

`default_nettype wire

// file: design/mds_ccgen.sv
// Condition code generator for a single word or a two-word product.
`default_nettype none

module mds_ccgen
  import mds_pkg::*;
(
  input  wire logic [15:0] hi_word,
  input  wire logic [15:0] lo_word,
  input  wire logic        whole,
  output logic             n_flag,
  output logic             z_flag,
  output logic             c_flag
);

  always_comb
  begin
    n_flag = hi_word[15];
    if (whole)
    begin
      z_flag = ({hi_word, lo_word} == {WORD_ZERO, WORD_ZERO});
      c_flag = (hi_word != {16{lo_word[15]}});
    end
    else
    begin
      z_flag = (hi_word == WORD_ZERO);
      c_flag = 1'b0;
    end
  end

endmodule : mds_ccgen

`default_nettype wire

// file: design/mds_seq.sv
// Multiply and non-restoring divide sequencer with its operand registers.
//
// Strobed register access and the register addresses were chosen for this implementation.
`default_nettype none

module mds_seq
  import mds_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        mul_start,
  input  wire logic        div_start,
  input  wire logic        abort,
  input  wire logic        brq,
  input  wire logic [2:0]  reg_sel,
  input  wire logic [15:0] src_operand,
  input  wire logic [15:0] dst_operand,
  input  wire logic [15:0] low_operand,
  output logic             busy,
  output logic             wr_en,
  output logic      [2:0]  wr_sel,
  output logic      [15:0] wr_data,
  output logic             cc_load,
  output logic             cc_n,
  output logic             cc_z,
  output logic             cc_v,
  output logic             cc_c,
  output logic             goto_break,
  output logic             goto_fetch,
  output logic             div_done,
  output logic             div_error,
  output logic      [15:0] quotient,
  output logic      [15:0] remainder
);

  // ---------------------------------------------------------------------
  // State and shared datapath
  // ---------------------------------------------------------------------
  mds_regs_t   s_ff;
  mds_regs_t   nxt_s;
  mds_state_t  st;
  logic [17:0] alu_a;
  logic [17:0] alu_b;
  logic        alu_sub;
  logic [17:0] alu_sum;
  logic [15:0] cc_hi;
  logic        cc_whole;
  logic        gen_n;
  logic        gen_z;
  logic        gen_c;
  logic        step_uf;
  logic        step_q;

  assign st = s_ff.microaddress_register;

  mds_addsub u_alu (
    .op_a (alu_a),
    .op_b (alu_b),
    .sub  (alu_sub),
    .sum  (alu_sum)
  );

  mds_ccgen u_cc (
    .hi_word (cc_hi),
    .lo_word (s_ff.destination_operand_reg),
    .whole   (cc_whole),
    .n_flag  (gen_n),
    .z_flag  (gen_z),
    .c_flag  (gen_c)
  );

  // ---------------------------------------------------------------------
  // ALU operand steering
  // ---------------------------------------------------------------------
  always_comb
  begin
    alu_a   = mds_zx18(s_ff.buffer_reg);
    alu_b   = mds_zx18(s_ff.source_operand_reg);
    alu_sub = 1'b0;
    case (st)
      product_add_shift_state,
      product_correct_state:
      begin
        // Signed operands keep the 17-bit partial product exact.
        alu_a   = mds_sx18(s_ff.buffer_reg);
        alu_b   = mds_sx18(s_ff.source_operand_reg);
        alu_sub = (st == product_correct_state); // RULE9
      end
      div_overflow_state:
      begin
        // The dividend is positive here, so equal signs mean a positive divisor.
        alu_b   = mds_sx18(s_ff.source_operand_reg);
        alu_sub = ~s_ff.source_operand_reg[15]; // RULE14
      end
      div_step_state:
      begin
        // Doubling the remainder stands in for halving the divisor weight.
        alu_a   = {s_ff.buffer_ext, s_ff.buffer_reg,
                   s_ff.destination_operand_reg[15]}; // RULE18
        alu_b   = mds_sx18(s_ff.source_operand_reg);
        alu_sub = (s_ff.buffer_ext == s_ff.source_operand_reg[15]); // RULE14
      end
      default:
      begin
        alu_sub = 1'b0;
      end
    endcase
  end

  // Underflow is a sign flip of the partial remainder across the reduction.
  assign step_uf = (alu_sum[17] != alu_a[17]); // RULE20
  assign step_q  = alu_sub ? ~step_uf : step_uf; // RULE16 RULE17

  always_comb
  begin
    cc_whole = (st == product_low_store_state);
    cc_hi    = s_ff.buffer_reg;
    // The last multiply cycle shifts once more, so the high half that is
    // stored and tested is the word after that shift.
    if (st == product_correct_state)
    begin
      cc_hi = alu_sum[16:1];
    end
    else if (st == product_nocorrect_state)
    begin
      cc_hi = {s_ff.buffer_reg[15], s_ff.buffer_reg[15:1]};
    end
  end

  // ---------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------
  always_comb
  begin
    nxt_s            = s_ff;
    nxt_s.wr_en      = 1'b0;
    nxt_s.cc_load    = 1'b0;
    nxt_s.goto_break = 1'b0;
    nxt_s.goto_fetch = 1'b0;
    nxt_s.div_done   = 1'b0;
    nxt_s.div_error  = 1'b0;
    case (st)
      idle_state:
      begin
        if (mul_start)
        begin
          nxt_s.source_operand_reg   = src_operand; // RULE2
          nxt_s.named_reg            = reg_sel;
          nxt_s.microaddress_register = product_load_state;
        end
        else if (div_start)
        begin
          nxt_s.source_operand_reg      = src_operand; // RULE21
          nxt_s.buffer_reg              = dst_operand;
          nxt_s.destination_operand_reg = low_operand;
          nxt_s.buffer_ext              = 1'b0;
          nxt_s.shift_counter           = SC_INIT;
          nxt_s.microaddress_register   = div_check_state;
        end
      end
      product_load_state:
      begin
        nxt_s.destination_operand_reg = dst_operand; // RULE5
        nxt_s.shift_counter           = SC_INIT;
        nxt_s.microaddress_register   = product_clear_state;
      end
      product_clear_state:
      begin
        nxt_s.buffer_reg    = WORD_ZERO; // RULE6
        nxt_s.shift_counter = s_ff.shift_counter - SC_STEP;
        // The multiplicand is not shifted yet, so bit 0 picks the first cycle.
        nxt_s.microaddress_register = s_ff.destination_operand_reg[0]
                                      ? product_add_shift_state
                                      : product_shift_state; // RULE4
      end
      product_add_shift_state,
      product_shift_state:
      begin
        if (st == product_add_shift_state)
        begin
          // The sum's own sign fills the top: that is the multiplier sign once
          // anything was added, and a still-zero partial product stays zero.
          nxt_s.buffer_reg = alu_sum[16:1]; // RULE3 RULE7
          nxt_s.destination_operand_reg = {alu_sum[0],
                                           s_ff.destination_operand_reg[15:1]};
        end
        else
        begin
          nxt_s.buffer_reg = {s_ff.buffer_reg[15], s_ff.buffer_reg[15:1]}; // RULE3
          nxt_s.destination_operand_reg = {s_ff.buffer_reg[0],
                                           s_ff.destination_operand_reg[15:1]};
        end
        nxt_s.shift_counter = s_ff.shift_counter - SC_STEP;
        // Bit 1 is the bit that lands in the low position with this shift, so
        // the branch sees the value the next state starts with, as the
        // time-pulse clocked microaddress would.
        if (s_ff.shift_counter == SC_ZERO)
        begin
          nxt_s.microaddress_register = s_ff.destination_operand_reg[1]
                                        ? product_correct_state
                                        : product_nocorrect_state; // RULE4 RULE8
        end
        else
        begin
          nxt_s.microaddress_register = s_ff.destination_operand_reg[1]
                                        ? product_add_shift_state
                                        : product_shift_state; // RULE4 RULE7
        end
      end
      product_nocorrect_state,
      product_correct_state:
      begin
        nxt_s.buffer_reg           = cc_hi; // RULE9
        nxt_s.destination_operand_reg = {((st == product_correct_state) ? alu_sum[0]
                                          : s_ff.buffer_reg[0]),
                                         s_ff.destination_operand_reg[15:1]};
        nxt_s.wr_en                = 1'b1; // RULE10 RULE23
        nxt_s.wr_sel               = s_ff.named_reg; // RULE1
        nxt_s.wr_data              = cc_hi;
        nxt_s.cc_load              = 1'b1;
        nxt_s.cc_n                 = gen_n;
        nxt_s.cc_z                 = gen_z;
        nxt_s.cc_v                 = 1'b0;
        nxt_s.cc_c                 = gen_c;
        nxt_s.break_request_sample = brq; // RULE13
        nxt_s.microaddress_register = product_low_store_state;
      end
      product_low_store_state:
      begin
        nxt_s.wr_en   = 1'b1; // RULE23
        nxt_s.wr_sel  = s_ff.named_reg | ODD_REG; // RULE1 RULE11
        nxt_s.wr_data = s_ff.destination_operand_reg;
        nxt_s.cc_load = 1'b1; // RULE12
        nxt_s.cc_n    = gen_n;
        nxt_s.cc_z    = gen_z;
        nxt_s.cc_v    = 1'b0;
        nxt_s.cc_c    = gen_c;
        nxt_s.goto_break = s_ff.break_request_sample; // RULE13
        nxt_s.goto_fetch = ~s_ff.break_request_sample;
        nxt_s.microaddress_register = idle_state;
      end
      div_check_state:
      begin
        if (s_ff.source_operand_reg == WORD_ZERO)
        begin
          nxt_s.cc_load   = 1'b1; // RULE22
          nxt_s.cc_n      = 1'b0;
          nxt_s.cc_z      = 1'b1;
          nxt_s.cc_v      = 1'b1;
          nxt_s.cc_c      = 1'b1;
          nxt_s.div_error = 1'b1;
          nxt_s.div_done  = 1'b1;
          nxt_s.microaddress_register = idle_state;
        end
        else
        begin
          nxt_s.microaddress_register = div_overflow_state;
        end
      end
      div_overflow_state:
      begin
        // A trial reduction of the unshifted high half that does not
        // underflow means the quotient needs more than one word.
        if (!step_uf)
        begin
          nxt_s.cc_load   = 1'b1; // RULE19
          nxt_s.cc_n      = 1'b0;
          nxt_s.cc_z      = 1'b0;
          nxt_s.cc_v      = 1'b1;
          nxt_s.cc_c      = 1'b0;
          nxt_s.div_error = 1'b1;
          nxt_s.div_done  = 1'b1;
          nxt_s.microaddress_register = idle_state;
        end
        else
        begin
          nxt_s.microaddress_register = div_step_state;
        end
      end
      div_step_state:
      begin
        // No restore on underflow: the next step simply reduces the other way.
        {nxt_s.buffer_ext, nxt_s.buffer_reg} = alu_sum[16:0]; // RULE15
        nxt_s.destination_operand_reg = {s_ff.destination_operand_reg[14:0],
                                         step_q}; // RULE21
        nxt_s.shift_counter = s_ff.shift_counter - SC_STEP;
        if (s_ff.shift_counter == SC_ZERO)
        begin
          nxt_s.microaddress_register = div_done_state;
        end
      end
      div_done_state:
      begin
        nxt_s.quotient  = s_ff.destination_operand_reg;
        nxt_s.remainder = s_ff.buffer_reg;
        nxt_s.div_done  = 1'b1;
        nxt_s.microaddress_register = idle_state;
      end
      default:
      begin
        nxt_s.microaddress_register = idle_state;
      end
    endcase
    // An abort cancels any store not yet issued; a high-half store already on wr_en in product_low_store_state still lands.
    if (abort && (st != idle_state))
    begin
      nxt_s.microaddress_register = idle_state; // RULE23
      nxt_s.wr_en      = 1'b0;
      nxt_s.cc_load    = 1'b0;
      nxt_s.goto_break = 1'b0;
      nxt_s.goto_fetch = 1'b0;
      nxt_s.div_done   = 1'b0;
      nxt_s.div_error  = 1'b0;
    end
    nxt_s.busy = (nxt_s.microaddress_register != idle_state);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_ff <= '0;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  assign busy       = s_ff.busy;
  assign wr_en      = s_ff.wr_en;
  assign wr_sel     = s_ff.wr_sel;
  assign wr_data    = s_ff.wr_data;
  assign cc_load    = s_ff.cc_load;
  assign cc_n       = s_ff.cc_n;
  assign cc_z       = s_ff.cc_z;
  assign cc_v       = s_ff.cc_v;
  assign cc_c       = s_ff.cc_c;
  assign goto_break = s_ff.goto_break;
  assign goto_fetch = s_ff.goto_fetch;
  assign div_done   = s_ff.div_done;
  assign div_error  = s_ff.div_error;
  assign quotient   = s_ff.quotient;
  assign remainder  = s_ff.remainder;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  load_init_a: assert property (@(posedge clk) disable iff (rst || abort) // RULE5
    st == product_load_state |=> s_ff.shift_counter == SC_INIT
      && s_ff.destination_operand_reg == $past(dst_operand))
    else $error("setup did not load operand and counter");

  clear_buf_a: assert property (@(posedge clk) disable iff (rst || abort) // RULE6
    st == product_clear_state |=> s_ff.buffer_reg == WORD_ZERO
      && s_ff.shift_counter == 4'hE)
    else $error("second setup state did not clear and decrement");

  sign_copy_a: assert property (@(posedge clk) disable iff (rst || abort) // RULE3
    (st == product_add_shift_state || st == product_shift_state)
      |=> s_ff.buffer_reg[15] == (s_ff.source_operand_reg[15]
        && (s_ff.buffer_reg != WORD_ZERO || s_ff.destination_operand_reg[15])))
    else $error("multiplier sign not copied after shift");

  fifteen_cycles_a: assert property (@(posedge clk) disable iff (rst || abort) // RULE7
    st == product_clear_state |=> ##15 (st == product_correct_state
      || st == product_nocorrect_state))
    else $error("multiply loop did not run fifteen cycles");

  high_store_a: assert property (@(posedge clk) disable iff (rst || abort) // RULE10
    (st == product_correct_state || st == product_nocorrect_state)
      |=> wr_en && cc_load && wr_sel == s_ff.named_reg && wr_data == s_ff.buffer_reg)
    else $error("high product half not stored");

  low_store_a: assert property (@(posedge clk) disable iff (rst || abort) // RULE11
    st == product_low_store_state |=> wr_en
      && wr_sel == (s_ff.named_reg | ODD_REG) && wr_data == s_ff.destination_operand_reg)
    else $error("low product half not stored to paired register");

  break_route_a: assert property (@(posedge clk) disable iff (rst || abort) // RULE13
    st == product_low_store_state |=> goto_break == $past(s_ff.break_request_sample)
      && goto_fetch == !goto_break)
    else $error("wrong exit after final store");

  zero_div_a: assert property (@(posedge clk) disable iff (rst || abort) // RULE22
    (st == div_check_state && s_ff.source_operand_reg == WORD_ZERO)
      |=> cc_c && cc_v && cc_z && div_error && !busy)
    else $error("zero divisor not flagged");

  qbit_sign_a: assert property (@(posedge clk) disable iff (rst || abort) // RULE16
    st == div_step_state |=> s_ff.destination_operand_reg[0]
      == (s_ff.buffer_ext == s_ff.source_operand_reg[15]))
    else $error("quotient bit disagrees with remainder sign");

  store_only_a: assert property (@(posedge clk) disable iff (rst) // RULE23
    wr_en |-> $past(st) inside {product_correct_state, product_nocorrect_state,
      product_low_store_state})
    else $error("register write outside store states");

endmodule : mds_seq

`default_nettype wire

// file: test/mds_regfile_model.sv
// Model of the general register file that sits behind the sequencer's write port.
`default_nettype none

module mds_regfile_model
  import mds_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        wr_en,
  input wire logic [2:0]  wr_sel,
  input wire logic [15:0] wr_data
);
  timeunit 1ns;
  timeprecision 100ps;

  // Reset fills a marker pattern so that a stray write is easy to see.
  logic [15:0] regs [8];
  int          n_writes;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < 8; i++) regs[i] <= 16'hA5A5;
      n_writes <= 0;
    end
    else if (wr_en)
    begin
      regs[wr_sel] <= wr_data;
      n_writes     <= n_writes + 1;
    end
  end
endmodule : mds_regfile_model

`default_nettype wire

// file: test/mds_seq_test.sv
// Self-checking bench for the multiply and divide sequencer.
`default_nettype none

module mds_seq_test
  import mds_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        mul_start = 1'b0;
  logic        div_start = 1'b0;
  logic        abort = 1'b0;
  logic        brq = 1'b0;
  logic [2:0]  reg_sel = 3'h0;
  logic [15:0] src_operand = 16'h0000;
  logic [15:0] dst_operand = 16'h0000;
  logic [15:0] low_operand = 16'h0000;
  logic        busy, wr_en, cc_load, cc_n, cc_z, cc_v, cc_c;
  logic        goto_break, goto_fetch, div_done, div_error;
  logic [2:0]  wr_sel;
  logic [15:0] wr_data, quotient, remainder;
  int          n_errors = 0;
  int          total_checks = 0;
  int          n_done = 0;

  initial forever #12.5 clk = ~clk;

  mds_seq dut (.clk(clk), .rst(rst), .mul_start(mul_start), .div_start(div_start),
    .abort(abort), .brq(brq), .reg_sel(reg_sel), .src_operand(src_operand),
    .dst_operand(dst_operand), .low_operand(low_operand), .busy(busy), .wr_en(wr_en),
    .wr_sel(wr_sel), .wr_data(wr_data), .cc_load(cc_load), .cc_n(cc_n), .cc_z(cc_z),
    .cc_v(cc_v), .cc_c(cc_c), .goto_break(goto_break), .goto_fetch(goto_fetch),
    .div_done(div_done), .div_error(div_error), .quotient(quotient), .remainder(remainder));

  mds_regfile_model model (.clk(clk), .rst(rst), .wr_en(wr_en), .wr_sel(wr_sel),
    .wr_data(wr_data));

  always @(posedge clk) if (div_done === 1'b1) n_done++;

  // ----------------------------------------------------------------
  // Checking and access tasks
  // ----------------------------------------------------------------
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_word

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  // Counts edges after the edge that raised the start until the awaited pulse shows.
  task automatic wait_for(input bit dv, output int n);
    n = 1;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (!((dv ? div_done : wr_en) === 1'b1) && n < 40);
    if (n >= 40)
    begin
      n_errors++;
      report_and_stop();
    end
  endtask : wait_for

  // The multiplicand follows one cycle after the start, and the multiplier and register select are
  // scrambled once taken so that late sampling shows up as a wrong product or a wrong register.
  task automatic mul_op(input logic [2:0] sel, input logic [15:0] a, input logic [15:0] b,
                        input logic bq);
    logic [31:0] p;
    logic [2:0]  lo_sel;
    int          n;
    p = $signed(a) * $signed(b);
    lo_sel = sel | ODD_REG;
    @(posedge clk);
    mul_start <= 1'b1;
    reg_sel <= sel;
    src_operand <= a;
    dst_operand <= ~b;
    brq <= bq;
    @(posedge clk);
    mul_start <= 1'b0;
    dst_operand <= b;
    reg_sel <= ~sel;
    src_operand <= ~a;
    wait_for(1'b0, n);
    chk_word(16'(n), 16'h0013, "high store cycle");
    chk_word({13'h0, wr_sel}, {13'h0, sel}, "high reg");
    chk_word(wr_data, p[31:16], "high half");
    chk_word({11'h0, cc_load, cc_n, cc_z, cc_v, cc_c},
             {11'h0, 1'b1, p[31], p[31:16] == WORD_ZERO, 2'b00}, "high codes");
    @(posedge clk);
    #1;
    chk_word({12'h0, wr_en, lo_sel}, {12'h1, lo_sel}, "low reg");
    chk_word(wr_data, p[15:0], "low half");
    chk_word({11'h0, cc_load, cc_n, cc_z, cc_v, cc_c}, {11'h0, 1'b1, p[31], p == 32'h0,
             1'b0, p[31:16] != {16{p[15]}}}, "low codes");
    chk_word({14'h0, goto_break, goto_fetch}, {14'h0, bq, ~bq}, "next flow");
    @(posedge clk);
    #1;
    brq <= 1'b0;
    chk_word(model.regs[lo_sel], p[15:0], "file low");
    if (sel != lo_sel) chk_word(model.regs[sel], p[31:16], "file high");
    chk_word({15'h0, busy}, 16'h0000, "busy after");
  endtask : mul_op

  task automatic div_op(input logic [15:0] dvs, input logic [15:0] hi, input logic [15:0] lo,
                        input int cyc, input logic err, input logic [15:0] q,
                        input logic [15:0] r, input logic [4:0] cc);
    int n;
    @(posedge clk);
    div_start <= 1'b1;
    src_operand <= dvs;
    dst_operand <= hi;
    low_operand <= lo;
    @(posedge clk);
    div_start <= 1'b0;
    src_operand <= ~dvs;
    dst_operand <= ~hi;
    low_operand <= ~lo;
    wait_for(1'b1, n);
    chk_word(16'(n), 16'(cyc), "divide length");
    chk_word({15'h0, div_error}, {15'h0, err}, "divide error");
    if (err) chk_word({11'h0, cc_load, cc_n, cc_z, cc_v, cc_c}, {11'h0, cc},
                      "divide codes");
    else chk_word(quotient, q, "quotient");
    if (!err) chk_word(remainder, r, "remainder");
    @(posedge clk);
  endtask : div_op

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    int w0;
    int d0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk_word({10'h0, busy, wr_en, cc_load, goto_break, goto_fetch, div_done}, 16'h0000, "reset");
    mul_op(3'h2, 16'h0003, 16'h0005, 1'b0);
    mul_op(3'h4, 16'hFFFD, 16'h0005, 1'b1);
    mul_op(3'h6, 16'h1234, 16'h8000, 1'b0);
    mul_op(3'h3, 16'h8000, 16'h8000, 1'b1);
    mul_op(3'h0, 16'h7FFF, 16'hFFFF, 1'b0);
    mul_op(3'h0, 16'h0000, 16'h1234, 1'b0);
    // Abort in mid-multiply, with a refused divide start while busy.
    w0 = model.n_writes;
    d0 = n_done;
    @(posedge clk);
    mul_start <= 1'b1;
    reg_sel <= 3'h2;
    src_operand <= 16'h0005;
    @(posedge clk);
    mul_start <= 1'b0;
    dst_operand <= 16'h0007;
    repeat (4) @(posedge clk);
    div_start <= 1'b1;
    @(posedge clk);
    div_start <= 1'b0;
    abort <= 1'b1;
    @(posedge clk);
    abort <= 1'b0;
    repeat (25) @(posedge clk);
    #1;
    chk_word(16'(model.n_writes - w0), 16'h0000, "writes after abort");
    chk_word({15'h0, busy}, 16'h0000, "busy after abort");
    chk_word(16'(n_done - d0), 16'h0000, "refused start");
    div_op(16'h0000, 16'h0000, 16'h0064, 2, 1'b1, 16'h0, 16'h0, 5'b10111);
    div_op(16'h0009, 16'h0009, 16'h0000, 3, 1'b1, 16'h0, 16'h0, 5'b10010);
    div_op(16'h0009, 16'h0000, 16'h0064, 20, 1'b0, 16'h000B, 16'h0001, 5'h0);
    div_op(16'h0003, 16'h0001, 16'h0000, 20, 1'b0, 16'h5555, 16'h0001, 5'h0);
    div_op(16'h0009, 16'h0008, 16'hFFFF, 20, 1'b0, 16'hFFFF, 16'h0008, 5'h0);
    report_and_stop();
  end
endmodule : mds_seq_test

`default_nettype wire
